// ### inc/timer_params.svh
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_RUN 8'h80
`define IDX_PRESCALE 8'h81
`define IDX_DBUF 8'h82
`define IDX_FLOP 8'h83
`define IDX_MODE_ONE 8'h84
`define IDX_MODE_TWO 8'h85
`define IDX_CMP0 8'h88
`define IDX_CMP1 8'h89
`define IDX_CMP2 8'h8A
`define IDX_CMP3 8'h8B
`define IDX_IRQ_STAT 8'h90
`define IDX_IRQ_CLR 8'h91
`define IDX_IRQ_EN 8'h92

// Field positions
`define PRESCALE_RUN_BIT 7
`define FLOP_PAIR_STRIDE 4
`define FLOP_INV_EN_BIT 0
`define FLOP_INV_SEL_BIT 1
`define FLOP_CMD_LSB 2
`define FLOP_CMD_SET 2'b01
`define FLOP_CMD_CLR 2'b10

// Reset values
`define MODE_RST 8'h00
`define RUN_RST 4'h0
`define DBUF_RST 2'h0
`define IRQ_RST 4'h0
`define CMP_RST 8'h00

// Prescaler: input is the system clock divided by four
`define FC_DIV_LAST 2'h3
`define TAP_DIV8_BIT 0
`define TAP_DIV32_BIT 2
`define TAP_DIV128_BIT 4
`define TAP_DIV2048_BIT 8

// PWM period tops (2^n - 1)
`define PWM_TOP_6 8'h3F
`define PWM_TOP_7 8'h7F
`define PWM_TOP_8 8'hFF

`endif

// ### inc/timer_pkg.sv
package timer_pkg;

   typedef enum logic [1:0]
   {
      MODE_8BIT = 2'b00,
      MODE_16BIT = 2'b01,
      MODE_PPG = 2'b10,
      MODE_PWM = 2'b11
   } pair_operating_mode_t;

   typedef struct packed
   {
      pair_operating_mode_t pair_operating_mode;
      logic [1:0] pwm_period_select;
      logic [1:0] upper_clock_select;
      logic [1:0] lower_clock_select;
   } pair_mode_t;

   typedef struct packed
   {
      logic div8;
      logic div32;
      logic div128;
      logic div2048;
   } tap_t;

endpackage

// ### sim/interval_timer_block_asserts.sv
`timescale 1ns/1ps
`include "timer_params.svh"

module interval_timer_block_asserts
   import timer_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic irq,
   input wire logic first_timer_output_pin,
   input wire logic second_timer_output_pin
);
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   logic [7:0] idx;
   assign idx = paddr[9:2];

   function automatic logic is_mapped(input logic [7:0] i);
      return (i >= `IDX_RUN && i <= `IDX_MODE_TWO) || (i >= `IDX_CMP0 && i <= `IDX_CMP3)
         || (i >= `IDX_IRQ_STAT && i <= `IDX_IRQ_EN);
   endfunction

   function automatic logic is_write_only(input logic [7:0] i);
      return (i >= `IDX_CMP0 && i <= `IDX_CMP3) || i == `IDX_IRQ_CLR;
   endfunction

   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   ready_after_wait_a: assert property (psel && penable && !pready |=> pready)
      else $error("ready missing one cycle into access");
   ready_needs_access_a: assert property (pready |-> $past(psel) && $past(penable) && psel && penable)
      else $error("ready outside an access phase");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("error flag without ready");
   idle_data_zero_a: assert property (!pready |-> prdata == 32'h00000000)
      else $error("read data not zero outside answer");
   upper_data_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   unmapped_err_a: assert property (pready |-> pslverr == !is_mapped(idx))
      else $error("error flag does not match address map");
   write_only_zero_a: assert property (pready && !pwrite && is_write_only(idx) |-> prdata == 32'h00000000)
      else $error("write-only register returned data");

   cover property (pready && pwrite);
   cover property (pready && pslverr);
   cover property ($rose(irq));
   cover property ($rose(second_timer_output_pin));
endmodule

bind interval_timer_block interval_timer_block_asserts #(.ADDR_W(ADDR_W)) chk
(
   .clk(clk),
   .rst_n(rst_n),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr),
   .irq(irq),
   .first_timer_output_pin(first_timer_output_pin),
   .second_timer_output_pin(second_timer_output_pin)
);

// ### sim/test_interval_timer_block.sv
`timescale 1ns/1ps
`include "timer_params.svh"

module test_interval_timer_block;
   logic clk, rst_n, psel, penable, pwrite, err, mon_sel;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd;
   logic [31:0] prdata;
   logic pready, pslverr, irq, pin1, pin2;
   int bad_count, n_compared, h1, h2;
   wire mon_pin = mon_sel ? pin2 : pin1;

   interval_timer_block #(.ADDR_W(12)) dut
   (
      .clk(clk),
      .rst_n(rst_n),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .irq(irq),
      .first_timer_output_pin(pin1),
      .second_timer_output_pin(pin2)
   );

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task report_and_stop;
      begin
         $display("compared %0d mismatches %0d", n_compared, bad_count);
         if (bad_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask

   task check(input logic [31:0] got, input logic [31:0] exp);
      begin
         n_compared++;
         if (got !== exp)
         begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask

   task timeout;
      begin
         bad_count++;
         $display("[ERR] t=%0t wait limit got=%h exp=%h", $time, 32'h0, 32'h1);
         report_and_stop();
      end
   endtask

   // Request held until the edge that samples pready high; released only after it
   task apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
      int k;
      begin
         k = 0;
         @(posedge clk);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= wr;
         paddr <= {2'b00, idx, 2'b00};
         pwdata <= {24'h000000, d};
         @(posedge clk);
         penable <= 1'b1;
         @(posedge clk);
         while (pready !== 1'b1)
         begin
            k++;
            if (k > 20)
               timeout();
            @(posedge clk);
         end
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d);
   endtask

   task rdreg(input logic [7:0] idx);
      apb(1'b0, idx, 8'h00);
   endtask

   // Cycles until the watched pin changes; in halves the first span is partial and thrown away
   task span(output int n);
      logic p;
      begin
         p = mon_pin;
         n = 0;
         do
         begin
            @(posedge clk);
            n++;
            if (n > 5000)
               timeout();
         end
         while (mon_pin === p);
      end
   endtask

   task halves(input logic s);
      int k;
      begin
         mon_sel = s;
         span(k);
         span(h1);
         span(h2);
      end
   endtask

   task stop_all;
      begin
         wr(`IDX_RUN, 8'h00);
         wr(`IDX_FLOP, 8'h88);
      end
   endtask

   task test_regs;
      begin
         rdreg(`IDX_MODE_ONE);
         check(rd, 32'h00000000);
         wr(`IDX_MODE_TWO, 8'hA5);
         rdreg(`IDX_MODE_TWO);
         check(rd, 32'h000000A5);
         rdreg(8'h86);
         check({31'h0, err}, 32'h00000001);
         rdreg(`IDX_CMP0);
         check(rd, 32'h00000000);
         wr(`IDX_FLOP, 8'h04);
         repeat (2) @(posedge clk);
         check({pin2, pin1}, 32'h00000001);
         wr(`IDX_FLOP, 8'h88);
         // Lower clock code 00 must give no ticks, so the flop stays put
         wr(`IDX_MODE_ONE, 8'h00);
         wr(`IDX_CMP0, 8'h01);
         wr(`IDX_FLOP, 8'h01);
         wr(`IDX_PRESCALE, 8'h80);
         wr(`IDX_RUN, 8'h01);
         repeat (300) @(posedge clk);
         check({31'h0, pin1}, 32'h00000000);
         stop_all();
         $display("test regs done");
      end
   endtask

   task test_interval;
      int k;
      begin
         wr(`IDX_MODE_ONE, 8'h05);
         wr(`IDX_CMP1, 8'h03);
         wr(`IDX_IRQ_EN, 8'h02);
         wr(`IDX_FLOP, 8'h03);
         wr(`IDX_RUN, 8'h02);
         halves(1'b0);
         check(h1, 32'd24);
         check(h2, 32'd24);
         k = 0;
         while (irq !== 1'b1)
         begin
            @(posedge clk);
            k++;
            if (k > 100)
               timeout();
         end
         rdreg(`IDX_IRQ_STAT);
         check(rd & 32'h2, 32'h00000002);
         wr(`IDX_IRQ_EN, 8'h00);
         repeat (2) @(posedge clk);
         check({31'h0, irq}, 32'h00000000);
         wr(`IDX_RUN, 8'h00);
         wr(`IDX_IRQ_CLR, 8'h0F);
         rdreg(`IDX_IRQ_STAT);
         check(rd, 32'h00000000);
         stop_all();
         $display("test interval done");
      end
   endtask

   task test_zero_and_cascade;
      begin
         wr(`IDX_MODE_ONE, 8'h01);
         wr(`IDX_CMP0, 8'h00);
         wr(`IDX_FLOP, 8'h01);
         wr(`IDX_RUN, 8'h01);
         halves(1'b0);
         check(h1, 32'd2048);
         stop_all();
         wr(`IDX_CMP0, 8'h03);
         wr(`IDX_CMP1, 8'h02);
         wr(`IDX_FLOP, 8'h03);
         wr(`IDX_RUN, 8'h03);
         halves(1'b0);
         check(h2, 32'd48);
         stop_all();
         $display("test zero and cascade done");
      end
   endtask

   task test_wide;
      logic p;
      begin
         // Upper clock field set to 11 on purpose: the wide mode must ignore it
         wr(`IDX_MODE_TWO, 8'h4D);
         wr(`IDX_CMP2, 8'h02);
         wr(`IDX_CMP3, 8'h01);
         wr(`IDX_FLOP, 8'h10);
         wr(`IDX_RUN, 8'h0C);
         halves(1'b1);
         check(h1, 32'd2064);
         wr(`IDX_PRESCALE, 8'h00);
         // A tap pulse already in flight may still land, so look only after it
         repeat (3) @(posedge clk);
         p = pin2;
         repeat (2200) @(posedge clk);
         check({31'h0, pin2}, {31'h0, p});
         stop_all();
         $display("test wide done");
      end
   endtask

   // Period 64 ticks of div8; buffered compare must wait for the first overflow
   task test_pwm;
      int k;
      begin
         wr(`IDX_PRESCALE, 8'h00);
         wr(`IDX_MODE_ONE, 8'hD1);
         wr(`IDX_CMP0, 8'h10);
         wr(`IDX_DBUF, 8'h01);
         wr(`IDX_CMP0, 8'h20);
         wr(`IDX_FLOP, 8'h01);
         wr(`IDX_RUN, 8'h01);
         wr(`IDX_PRESCALE, 8'h80);
         mon_sel = 1'b0;
         span(k);
         check({31'h0, (k >= 128 && k <= 136)}, 32'h00000001);
         span(h1);
         span(h2);
         check(h1, 32'd384);
         check(h2, 32'd256);
         stop_all();
         wr(`IDX_DBUF, 8'h00);
         $display("test pwm done");
      end
   endtask

   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      rst_n = 1'b0;
      mon_sel = 1'b0;
      bad_count = 0;
      n_compared = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      test_regs();
      test_interval();
      test_zero_and_cascade();
      test_wide();
      test_pwm();
      report_and_stop();
   end
endmodule

// ### src/interval_timer_block.sv
//
// Overview of operation
// RULE_01: Mode field 7:6 picks dual 8-bit, 16-bit, PPG, or PWM plus timer.
// RULE_02: Lower clock div8/32/128, code 00 reserved; upper div8/128/2048 or lower match.
// RULE_03: Cascaded 16-bit pair counts 1 to 65536 input clocks.
// RULE_04: Counter equal to compare clears counter, raises request, may toggle flop.
// RULE_05: Each pair owns one output flop driving its own output pin.
// RULE_06: Toggling on every fixed-interval match gives a 50% duty square wave.
// RULE_07: Software writes buffered compare six clocks before overflow or cycle match.
// RULE_08: Both timer pairs work independently and identically.
// RULE_09: Software stops, configures, enables interrupt, then starts the timer.
// RULE_10: Run bit 0 stops and clears the counter; 1 starts counting.
// RULE_11: In 8-bit mode upper timer may count lower comparator matches.
// RULE_12: In 16-bit mode upper timer counts lower overflow, ignoring its clock select.
// RULE_13: Compare registers are write-only, reset-undefined, no read-modify-write.
// RULE_14: Prescaler counts only while its run bit is set; clear stops and clears it.
// RULE_15: Compare value zero matches on counter overflow, a full 256 count.
// RULE_16: Without double buffering lower compare writes both; with it, buffer only.
// RULE_17: PWM clears counter at 2^n-1, n of 6, 7, 8; output toggles at match and top.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "timer_params.svh"

module interval_timer_block
   import timer_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   output logic first_timer_output_pin,
   output logic second_timer_output_pin
);

   logic [7:0] idx;
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;
   logic commit;
   logic wr_en;
   logic hit;
   logic [31:0] rd_mux;

   logic [3:0] run_ff;
   logic prerun_ff;
   logic [1:0] dbuf_ff;
   logic [1:0] inv_en_ff;
   logic [1:0] inv_sel_ff;
   pair_mode_t mode_ff [2];
   logic [3:0] irq_en_ff;
   logic [3:0] irq_st_ff;
   logic irq_ff;
   logic [3:0] evt;
   logic [3:0] clr_mask;
   logic [1:0] flop_set;
   logic [1:0] flop_clr;
   tap_t taps;

   assign idx = paddr[9:2];
   assign commit = psel && penable && pready_ff;
   assign wr_en = commit && pwrite && !pslverr_ff;

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign irq = irq_ff;

   // Read mux; compare registers and the clear register read as zero
   always_comb
   begin
      hit = 1'b1;
      rd_mux = 32'h0000_0000;
      case (idx)
         `IDX_RUN:
         begin
            rd_mux = {28'h0000000, run_ff};
         end
         `IDX_PRESCALE:
         begin
            rd_mux[`PRESCALE_RUN_BIT] = prerun_ff;
         end
         `IDX_DBUF:
         begin
            rd_mux = {30'h00000000, dbuf_ff};
         end
         `IDX_FLOP:
         begin
            rd_mux[`FLOP_INV_EN_BIT] = inv_en_ff[0];
            rd_mux[`FLOP_INV_SEL_BIT] = inv_sel_ff[0];
            rd_mux[`FLOP_PAIR_STRIDE + `FLOP_INV_EN_BIT] = inv_en_ff[1];
            rd_mux[`FLOP_PAIR_STRIDE + `FLOP_INV_SEL_BIT] = inv_sel_ff[1];
         end
         `IDX_MODE_ONE:
         begin
            rd_mux = {24'h000000, mode_ff[0]};
         end
         `IDX_MODE_TWO:
         begin
            rd_mux = {24'h000000, mode_ff[1]};
         end
         `IDX_CMP0, `IDX_CMP1, `IDX_CMP2, `IDX_CMP3, `IDX_IRQ_CLR:
         begin
            rd_mux = 32'h0000_0000; // RULE_13
         end
         `IDX_IRQ_STAT:
         begin
            rd_mux = {28'h0000000, irq_st_ff};
         end
         `IDX_IRQ_EN:
         begin
            rd_mux = {28'h0000000, irq_en_ff};
         end
         default:
         begin
            hit = 1'b0;
         end
      endcase
   end

   // One wait state: answer is prepared on the first access edge
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end
      else if (psel && penable && !pready_ff)
      begin
         pready_ff <= 1'b1;
         pslverr_ff <= !hit;
         prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
      end
      else
      begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         run_ff <= `RUN_RST;
         prerun_ff <= 1'b0;
         dbuf_ff <= `DBUF_RST;
         irq_en_ff <= `IRQ_RST;
      end
      else if (wr_en)
      begin
         if (idx == `IDX_RUN)
         begin
            run_ff <= pwdata[3:0]; // RULE_10
         end
         if (idx == `IDX_PRESCALE)
         begin
            prerun_ff <= pwdata[`PRESCALE_RUN_BIT]; // RULE_14
         end
         if (idx == `IDX_DBUF)
         begin
            dbuf_ff <= pwdata[1:0];
         end
         if (idx == `IDX_IRQ_EN)
         begin
            irq_en_ff <= pwdata[3:0];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_ff[0] <= `MODE_RST;
         mode_ff[1] <= `MODE_RST;
      end
      else if (wr_en && idx == `IDX_MODE_ONE)
      begin
         mode_ff[0] <= pwdata[7:0];
      end
      else if (wr_en && idx == `IDX_MODE_TWO)
      begin
         mode_ff[1] <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         inv_en_ff <= 2'b00;
         inv_sel_ff <= 2'b00;
      end
      else if (wr_en && idx == `IDX_FLOP)
      begin
         inv_en_ff[0] <= pwdata[`FLOP_INV_EN_BIT];
         inv_sel_ff[0] <= pwdata[`FLOP_INV_SEL_BIT];
         inv_en_ff[1] <= pwdata[`FLOP_PAIR_STRIDE + `FLOP_INV_EN_BIT];
         inv_sel_ff[1] <= pwdata[`FLOP_PAIR_STRIDE + `FLOP_INV_SEL_BIT];
      end
   end

   assign flop_set[0] = wr_en && idx == `IDX_FLOP
                        && pwdata[`FLOP_CMD_LSB +: 2] == `FLOP_CMD_SET;
   assign flop_clr[0] = wr_en && idx == `IDX_FLOP
                        && pwdata[`FLOP_CMD_LSB +: 2] == `FLOP_CMD_CLR;
   assign flop_set[1] = wr_en && idx == `IDX_FLOP
                        && pwdata[`FLOP_PAIR_STRIDE + `FLOP_CMD_LSB +: 2] == `FLOP_CMD_SET;
   assign flop_clr[1] = wr_en && idx == `IDX_FLOP
                        && pwdata[`FLOP_PAIR_STRIDE + `FLOP_CMD_LSB +: 2] == `FLOP_CMD_CLR;

   assign clr_mask = (wr_en && idx == `IDX_IRQ_CLR) ? pwdata[3:0] : 4'h0;

   // A new event in the clearing cycle survives
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_st_ff <= `IRQ_RST;
         irq_ff <= 1'b0;
      end
      else
      begin
         irq_st_ff <= (irq_st_ff & ~clr_mask) | evt;
         irq_ff <= |(irq_st_ff & irq_en_ff);
      end
   end

   prescaler_taps u_prescaler
   (
      .clk(clk),
      .rst_n(rst_n),
      .run(prerun_ff),
      .taps(taps)
   );

   // Both pairs are the same circuit
   for (genvar p = 0; p < 2; p++) // RULE_08
   begin : g_pair
      localparam logic [7:0] LO_IDX = `IDX_CMP0 + 8'(2 * p);
      localparam logic [7:0] UP_IDX = `IDX_CMP1 + 8'(2 * p);
      pair_mode_t md;
      logic [7:0] lo_cnt_ff;
      logic [7:0] up_cnt_ff;
      logic [7:0] lo_cmp_ff;
      logic [7:0] lo_buf_ff;
      logic [7:0] up_cmp_ff;
      logic tff_ff;
      logic [7:0] lo_nxt;
      logic [7:0] up_nxt;
      logic [15:0] wide_nxt;
      logic [7:0] pwm_top;
      logic [7:0] nxt_lo_cnt;
      logic [7:0] nxt_up_cnt;
      logic lo_run;
      logic up_run;
      logic lo_tick;
      logic up_tick;
      logic lo_match;
      logic up_match;
      logic cycle_match;
      logic wide_match;
      logic pwm_ovf;
      logic lo_carry;
      logic toggle;

      assign md = mode_ff[p];
      assign lo_run = run_ff[2*p];
      assign up_run = run_ff[2*p+1];
      assign lo_nxt = lo_cnt_ff + 8'h01;
      assign up_nxt = up_cnt_ff + 8'h01;
      assign wide_nxt = {up_cnt_ff, lo_cnt_ff} + 16'h0001;

      always_comb
      begin
         case (md.lower_clock_select) // RULE_02
            2'b01: lo_tick = lo_run && taps.div8;
            2'b10: lo_tick = lo_run && taps.div32;
            2'b11: lo_tick = lo_run && taps.div128;
            default: lo_tick = 1'b0;
         endcase
         case (md.pwm_period_select) // RULE_17
            2'b01: pwm_top = `PWM_TOP_6;
            2'b10: pwm_top = `PWM_TOP_7;
            default: pwm_top = `PWM_TOP_8;
         endcase
      end

      // Zero compare matches when the incremented count wraps to zero
      assign lo_match = lo_tick && lo_nxt == lo_cmp_ff; // RULE_15
      assign cycle_match = lo_tick && lo_nxt == up_cmp_ff;
      assign pwm_ovf = lo_tick && lo_cnt_ff == pwm_top;
      assign lo_carry = lo_tick && lo_cnt_ff == 8'hFF;
      assign wide_match = lo_tick && wide_nxt == {up_cmp_ff, lo_cmp_ff}; // RULE_03

      always_comb
      begin
         up_tick = 1'b0;
         if (md.pair_operating_mode == MODE_16BIT)
         begin
            up_tick = up_run && lo_carry; // RULE_12
         end
         else if (md.pair_operating_mode != MODE_PPG)
         begin
            case (md.upper_clock_select) // RULE_02
               2'b00: up_tick = up_run && lo_match; // RULE_11
               2'b01: up_tick = up_run && taps.div8;
               2'b10: up_tick = up_run && taps.div128;
               default: up_tick = up_run && taps.div2048;
            endcase
         end
      end

      assign up_match = up_tick && up_nxt == up_cmp_ff;

      always_comb
      begin
         nxt_lo_cnt = lo_tick ? lo_nxt : lo_cnt_ff;
         nxt_up_cnt = up_tick ? up_nxt : up_cnt_ff;
         unique case (md.pair_operating_mode) // RULE_01
            MODE_8BIT:
            begin
               if (lo_match)
               begin
                  nxt_lo_cnt = 8'h00; // RULE_04
               end
               if (up_match)
               begin
                  nxt_up_cnt = 8'h00; // RULE_04
               end
            end
            MODE_16BIT:
            begin
               if (wide_match)
               begin
                  nxt_lo_cnt = 8'h00;
                  nxt_up_cnt = 8'h00;
               end
            end
            MODE_PPG:
            begin
               nxt_up_cnt = 8'h00;
               if (cycle_match)
               begin
                  nxt_lo_cnt = 8'h00;
               end
            end
            MODE_PWM:
            begin
               if (pwm_ovf)
               begin
                  nxt_lo_cnt = 8'h00; // RULE_17
               end
               if (up_match)
               begin
                  nxt_up_cnt = 8'h00;
               end
            end
         endcase
         if (!lo_run)
         begin
            nxt_lo_cnt = 8'h00; // RULE_10
         end
         if (!up_run)
         begin
            nxt_up_cnt = 8'h00; // RULE_10
         end
      end

      always_ff @(posedge clk or negedge rst_n)
      begin
         if (!rst_n)
         begin
            lo_cnt_ff <= 8'h00;
            up_cnt_ff <= 8'h00;
         end
         else
         begin
            lo_cnt_ff <= nxt_lo_cnt;
            up_cnt_ff <= nxt_up_cnt;
         end
      end

      // Buffered load at period end keeps a PWM/PPG cycle intact
      always_ff @(posedge clk or negedge rst_n)
      begin
         if (!rst_n)
         begin
            lo_cmp_ff <= `CMP_RST;
            lo_buf_ff <= `CMP_RST;
            up_cmp_ff <= `CMP_RST;
         end
         else
         begin
            if (wr_en && idx == LO_IDX)
            begin
               lo_buf_ff <= pwdata[7:0]; // RULE_16
            end
            if (wr_en && idx == LO_IDX && !dbuf_ff[p])
            begin
               lo_cmp_ff <= pwdata[7:0]; // RULE_16
            end
            else if (dbuf_ff[p] && ((md.pair_operating_mode == MODE_PWM && pwm_ovf)
                                    || (md.pair_operating_mode == MODE_PPG && cycle_match)))
            begin
               lo_cmp_ff <= lo_buf_ff; // RULE_16
            end
            if (wr_en && idx == UP_IDX)
            begin
               up_cmp_ff <= pwdata[7:0];
            end
         end
      end

      always_comb
      begin
         unique case (md.pair_operating_mode)
            MODE_8BIT: toggle = inv_sel_ff[p] ? up_match : lo_match; // RULE_06
            MODE_16BIT: toggle = wide_match;
            MODE_PPG: toggle = lo_match || cycle_match;
            MODE_PWM: toggle = lo_match || pwm_ovf; // RULE_17
         endcase
      end

      // Software set or clear overrides a toggle in the same cycle
      always_ff @(posedge clk or negedge rst_n)
      begin
         if (!rst_n)
         begin
            tff_ff <= 1'b0;
         end
         else if (flop_set[p])
         begin
            tff_ff <= 1'b1;
         end
         else if (flop_clr[p])
         begin
            tff_ff <= 1'b0;
         end
         else if (inv_en_ff[p] && toggle)
         begin
            tff_ff <= !tff_ff; // RULE_04
         end
      end

      assign evt[2*p] = (md.pair_operating_mode == MODE_8BIT && lo_match)
                        || (md.pair_operating_mode == MODE_PPG && cycle_match)
                        || (md.pair_operating_mode == MODE_PWM && pwm_ovf); // RULE_04
      assign evt[2*p+1] = (md.pair_operating_mode == MODE_16BIT) ? wide_match
                          : (md.pair_operating_mode != MODE_PPG && up_match);
   end

   assign first_timer_output_pin = g_pair[0].tff_ff; // RULE_05
   assign second_timer_output_pin = g_pair[1].tff_ff; // RULE_05

endmodule

// ### src/prescaler_taps.sv
`timescale 1ns/1ps
`include "timer_params.svh"

module prescaler_taps
   import timer_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   output tap_t taps
);

   logic [1:0] fc_div_ff;
   logic [8:0] pre_ff;
   logic pre_tick;

   assign pre_tick = run && (fc_div_ff == `FC_DIV_LAST);

   // Stopping also clears, so a restart always begins on a fresh phase
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fc_div_ff <= 2'h0;
         pre_ff <= 9'h000;
      end
      else if (!run)
      begin
         fc_div_ff <= 2'h0;
         pre_ff <= 9'h000;
      end
      else
      begin
         fc_div_ff <= fc_div_ff + 2'h1;
         if (pre_tick)
         begin
            pre_ff <= pre_ff + 9'h001;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         taps <= '0;
      end
      else
      begin
         taps.div8 <= pre_tick && (&pre_ff[`TAP_DIV8_BIT:0]);
         taps.div32 <= pre_tick && (&pre_ff[`TAP_DIV32_BIT:0]);
         taps.div128 <= pre_tick && (&pre_ff[`TAP_DIV128_BIT:0]);
         taps.div2048 <= pre_tick && (&pre_ff[`TAP_DIV2048_BIT:0]);
      end
   end

endmodule
